// file: bench/event_fabric_model.sv
`timescale 1ns/1ps
module event_fabric_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic wantA,
	input wire logic wantB,
	input wire logic wrapEvent,
	output logic eventInputA,
	output logic eventInputB,
	output logic [7:0] wrapCount
);
	// Levels change only at the clock, and the bench holds each one for several cycles
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			eventInputA <= 1'b0;
			eventInputB <= 1'b0;
		end else begin
			eventInputA <= wantA;
			eventInputB <= wantB;
		end
	end
	// A wrap pulse is counted once for every cycle it stays high, so width faults show up
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			wrapCount <= 8'h00;
		else if (wrapEvent)
			wrapCount <= wrapCount + 8'h01;
	end
endmodule // event_fabric_model

// file: bench/timer_event_irq_sleep_logic_test.sv
`timescale 1ns/1ps
module timer_event_irq_sleep_logic_test
	import timer_event_pkg::*;
;
	logic clk, rst, regWr, regRd, sleepStandby, sleepPowerDown, countStep, countingDown;
	logic wantA, wantB, eventInputA, eventInputB, timerRun, splitMode, eventCountGate;
	logic eventCountPulse, eventDirActive, eventDirDown, restartReq;
	logic wrapOrLowUnderflowEvent, highByteUnderflowEvent;
	logic [CMP_CH-1:0] compareMatchEventCh;
	logic [ADDR_W-1:0] regAddr;
	logic [DATA_W-1:0] regWrData, regRdData, irqReq, expFlags;
	logic [15:0] cntValue, perValue, cmp0Value, cmp1Value, cmp2Value;
	logic [7:0] wrapCount, expWraps;
	int miscompares, checksDone, cycles;
	logic [ADDR_W-1:0] ofs [6];

	timer_event_irq_sleep_logic timer_event_irq_sleep_logic_inst (.clk(clk), .rst(rst),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .sleepStandby(sleepStandby), .sleepPowerDown(sleepPowerDown),
		.eventInputA(eventInputA), .eventInputB(eventInputB), .cntValue(cntValue),
		.perValue(perValue), .cmp0Value(cmp0Value), .cmp1Value(cmp1Value),
		.cmp2Value(cmp2Value), .countStep(countStep), .countingDown(countingDown),
		.timerRun(timerRun), .splitMode(splitMode), .eventCountGate(eventCountGate),
		.eventCountPulse(eventCountPulse), .eventDirActive(eventDirActive),
		.eventDirDown(eventDirDown), .restartReq(restartReq),
		.wrapOrLowUnderflowEvent(wrapOrLowUnderflowEvent),
		.highByteUnderflowEvent(highByteUnderflowEvent),
		.compareMatchEventCh(compareMatchEventCh), .irqReq(irqReq));

	event_fabric_model event_fabric_model_inst (.clk(clk), .rst(rst), .wantA(wantA),
		.wantB(wantB), .wrapEvent(wrapOrLowUnderflowEvent), .eventInputA(eventInputA),
		.eventInputB(eventInputB), .wrapCount(wrapCount));

	// Free-running clock, 5 ns period
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checksDone++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic giveVerdict();
		$display("checks %0d, mismatches %0d", checksDone, miscompares);
		if (miscompares == 0 && checksDone > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			giveVerdict();
		end
	end

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1 check("read data", regRdData, exp);
	endtask

	// One count step; the events land one cycle later, on the same edge that sets the flags
	task automatic step(input logic [15:0] cnt, input logic dn, input logic w, input logic h,
		input logic [2:0] c);
		@(posedge clk);
		countStep <= 1'b1;
		cntValue <= cnt;
		countingDown <= dn;
		@(posedge clk);
		countStep <= 1'b0;
		#1 check("events", {wrapOrLowUnderflowEvent, highByteUnderflowEvent,
			compareMatchEventCh}, {w, h, c});
		expFlags = expFlags | {1'b0, c, 2'b00, h, w};
		expWraps = expWraps + {7'h00, w};
	endtask

	// Levels pass through the far-side model, then one registered stage
	task automatic ev(input logic a, input logic b, input logic [4:0] exp);
		@(posedge clk);
		wantA <= a;
		wantB <= b;
		repeat (2) @(posedge clk);
		#1 check("event input outputs", {eventCountGate, eventCountPulse, eventDirActive,
			eventDirDown, restartReq}, exp);
	endtask

	initial begin
		{regWr, regRd, sleepStandby, sleepPowerDown, countStep, countingDown} = 6'h00;
		{wantA, wantB, regAddr, regWrData, cntValue} = '0;
		perValue = 16'h0100;
		cmp0Value = 16'h0010;
		cmp1Value = 16'h0120;
		cmp2Value = 16'h0230;
		expFlags = 8'h00;
		expWraps = 8'h00;
		ofs = '{CTRL_OFS, MODE_OFS, EVENT_CONTROL_REG_OFS, IRQEN_OFS, IRQFLAG_OFS, 6'h3F};
		rst = 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		// Reset values, implemented bits, unmapped place
		foreach (ofs[i]) rd(ofs[i], REG_RESET);
		check("timerRun", timerRun, 1'b1);
		wr(IRQEN_OFS, 8'hFF);
		rd(IRQEN_OFS, IRQ_MASK);
		wr(6'h3F, 8'hFF);
		rd(6'h3F, 8'h00);
		$display("test registers done");
		// Normal mode conditions, flags set while sources are off
		wr(IRQEN_OFS, 8'h00);
		step(16'h0100, 1'b0, 1'b1, 1'b0, 3'b000);
		step(16'h0000, 1'b1, 1'b1, 1'b0, 3'b000);
		step(16'h0000, 1'b0, 1'b0, 1'b0, 3'b000);
		step(16'h0120, 1'b0, 1'b0, 1'b0, 3'b010);
		step(16'h0030, 1'b0, 1'b0, 1'b0, 3'b000);
		step(16'h0010, 1'b0, 1'b0, 1'b0, 3'b001);
		step(16'h0230, 1'b0, 1'b0, 1'b0, 3'b100);
		rd(IRQFLAG_OFS, expFlags);
		check("irqReq", irqReq, 8'h00);
		wr(IRQEN_OFS, IRQ_MASK);
		repeat (2) @(posedge clk);
		#1 check("irqReq", irqReq, expFlags);
		wr(IRQFLAG_OFS, 8'h00);
		rd(IRQFLAG_OFS, expFlags);
		wr(IRQFLAG_OFS, 8'h01);
		expFlags = expFlags & 8'hFE;
		rd(IRQFLAG_OFS, expFlags);
		check("irqReq", irqReq, expFlags);
		wr(IRQFLAG_OFS, 8'hFF);
		expFlags = 8'h00;
		$display("test normal mode done");
		// Split mode: byte underflows, low-byte compares, inputs ignored
		wr(MODE_OFS, 8'h01);
		#1 check("splitMode", splitMode, 1'b1);
		step(16'h0000, 1'b1, 1'b1, 1'b1, 3'b000);
		step(16'h0030, 1'b1, 1'b0, 1'b1, 3'b100);
		step(16'h0510, 1'b1, 1'b0, 1'b0, 3'b001);
		step(16'h0100, 1'b1, 1'b1, 1'b0, 3'b000);
		rd(IRQFLAG_OFS, expFlags);
		check("irqReq", irqReq, expFlags);
		wr(EVENT_CONTROL_REG_OFS, 8'h91);
		ev(1'b1, 1'b1, 5'b00000);
		ev(1'b0, 1'b0, 5'b00000);
		wr(MODE_OFS, 8'h00);
		wr(IRQFLAG_OFS, 8'hFF);
		expFlags = 8'h00;
		$display("test split mode done");
		// Every action of both inputs, rising then falling
		for (int a = 0; a < 4; a++) begin
			wr(EVENT_CONTROL_REG_OFS, {4'h0, 3'(a), 1'b1});
			ev(1'b1, 1'b0, {a < 3, a < 3, a == 3, a == 3, 1'b0});
			ev(1'b0, 1'b0, {a < 3, a == 1, a == 3, 1'b0, 1'b0});
		end
		for (int b = 3; b < 7; b++) begin
			wr(EVENT_CONTROL_REG_OFS, {3'(b), 1'b1, 4'h0});
			ev(1'b0, 1'b1, {2'b00, b == 3, b == 3, b != 3});
			ev(1'b0, 1'b0, {2'b00, b == 3, 1'b0, b == 5});
		end
		wr(EVENT_CONTROL_REG_OFS, 8'h77);
		ev(1'b0, 1'b1, 5'b00110);
		ev(1'b1, 1'b0, 5'b00110);
		ev(1'b0, 1'b0, 5'b00100);
		wr(EVENT_CONTROL_REG_OFS, 8'h66);
		ev(1'b1, 1'b1, 5'b00000);
		ev(1'b0, 1'b0, 5'b00000);
		$display("test event inputs done");
		// Sleep: halted by default, kept running on request, always halted in power-down
		@(posedge clk);
		sleepStandby <= 1'b1;
		#1 check("timerRun", timerRun, 1'b0);
		step(16'h0100, 1'b0, 1'b0, 1'b0, 3'b000);
		wr(CTRL_OFS, 8'h80);
		#1 check("timerRun", timerRun, 1'b1);
		step(16'h0100, 1'b0, 1'b1, 1'b0, 3'b000);
		@(posedge clk);
		sleepStandby <= 1'b0;
		sleepPowerDown <= 1'b1;
		#1 check("timerRun", timerRun, 1'b0);
		step(16'h0010, 1'b0, 1'b0, 1'b0, 3'b000);
		rd(IRQFLAG_OFS, expFlags);
		check("wrap pulses", wrapCount, expWraps);
		$display("test sleep done");
		giveVerdict();
	end
endmodule // timer_event_irq_sleep_logic_test

// file: rtl/event_edge_detect.sv
`timescale 1ns/1ps
module event_edge_detect
	import timer_event_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic level,
	output logic rise,
	output logic anyEdge
);

	logic prev_r;

	// Previous level keeps tracking in sleep so waking gives no stale edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prev_r <= 1'b0;
		end else begin
			prev_r <= level;
		end
	end

	assign rise = level & ~prev_r;
	assign anyEdge = level ^ prev_r;

endmodule // event_edge_detect

// file: rtl/irq_flag_bank.sv
`timescale 1ns/1ps
module irq_flag_bank
	import timer_event_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] setVec,
	input wire logic [WIDTH-1:0] clrVec,
	input wire logic [WIDTH-1:0] enVec,
	output logic [WIDTH-1:0] flags_r,
	output logic [WIDTH-1:0] req
);

	// A set in the clearing cycle wins so no event is lost
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flags_r <= '0;
		end else begin
			flags_r <= (flags_r & ~clrVec) | setVec; // see RULE15 see RULE21
		end
	end

	// Request held as long as flag and enable both stand
	assign req = flags_r & enVec; // see RULE17

endmodule // irq_flag_bank

// file: rtl/timer_event_irq_sleep_logic.sv
// Behaviour
// RULE1: Wrap event is overflow, or low-byte underflow in split; high-byte event split only.
// RULE2: Three compare events: channel match normally, low-byte channel match in split mode.
// RULE3: Events are one-clock pulses raised exactly when the matching flag is set.
// RULE4: Input A counts on rising edge, any edge, while high, or sets direction.
// RULE5: Input B sets direction, or restarts on rising edge, any edge, or while high.
// RULE6: A direction input counts up while low and down while high.
// RULE7: Action fields pick each input's behaviour; inputs act only when enabled.
// RULE8: Both inputs on direction: levels are ORed, up only when both low.
// RULE9: Split mode ignores both event inputs regardless of settings.
// RULE10: Level actions need the event source slower than the count rate.
// RULE11: Normal mode wrap condition at TOP counting up or BOTTOM counting down.
// RULE12: Normal mode compare condition when counter equals that channel's compare value.
// RULE13: Split mode raises low and high underflow when each byte timer hits BOTTOM.
// RULE14: Split mode compare conditions use low counter byte against low compare bytes.
// RULE15: Any condition sets its flag whether or not that source is enabled.
// RULE16: Each source has its own software enable bit.
// RULE17: Request stands while enabled and flagged, until the flag is cleared.
// RULE18: By default the timer stops at once in standby sleep.
// RULE19: With keep-running set the timer stays fully active in standby.
// RULE20: Power-down sleep halts everything regardless of keep-running.
// RULE21: Writing one clears a flag; writing zero leaves it.
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
module timer_event_irq_sleep_logic
	import timer_event_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [DATA_W-1:0] regRdData,
	input wire logic sleepStandby,
	input wire logic sleepPowerDown,
	input wire logic eventInputA,
	input wire logic eventInputB,
	input wire logic [15:0] cntValue,
	input wire logic [15:0] perValue,
	input wire logic [15:0] cmp0Value,
	input wire logic [15:0] cmp1Value,
	input wire logic [15:0] cmp2Value,
	input wire logic countStep,
	input wire logic countingDown,
	output logic timerRun,
	output logic splitMode,
	output logic eventCountGate,
	output logic eventCountPulse,
	output logic eventDirActive,
	output logic eventDirDown,
	output logic restartReq,
	output logic wrapOrLowUnderflowEvent,
	output logic highByteUnderflowEvent,
	output logic [CMP_CH-1:0] compareMatchEventCh,
	output logic [DATA_W-1:0] irqReq
);

	logic keepRunningInSleep_r;
	logic splitMode_r;
	logic [DATA_W-1:0] eventControl_r;
	logic [DATA_W-1:0] irqEnable_r;
	logic [DATA_W-1:0] irqFlags;
	logic [DATA_W-1:0] rdData_r;
	logic [DATA_W-1:0] rdData_nxt;
	logic [DATA_W-1:0] flagSet;
	logic [DATA_W-1:0] flagClr;
	logic run;
	logic aRise;
	logic aAny;
	logic bRise;
	logic bAny;
	logic aActive;
	logic bActive;
	a_action_t aAct;
	b_action_t bAct;
	logic dirA;
	logic dirB;
	logic wrapCond;
	logic highCond;
	logic [CMP_CH-1:0] cmpCond;
	logic countGate_nxt;
	logic countPulse_nxt;
	logic restart_nxt;
	logic countGate_r;
	logic countPulse_r;
	logic dirActive_r;
	logic dirDown_r;
	logic restart_r;
	logic wrapEvent_r;
	logic highEvent_r;
	logic [CMP_CH-1:0] cmpEvent_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Compare of one channel, picking full or low-byte width by mode
	function automatic logic cmpHit(input logic split, input logic [15:0] cnt,
		input logic [15:0] cmp);
		cmpHit = split ? (cnt[7:0] == cmp[7:0]) : (cnt == cmp);
	endfunction

	// Sleep gating: power-down always halts, standby halts unless kept running
	assign run = ~sleepPowerDown & // see RULE20
		~(sleepStandby & ~keepRunningInSleep_r); // see RULE18 see RULE19

	// Software-visible control bits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			keepRunningInSleep_r <= 1'b0;
			splitMode_r <= 1'b0;
		end else if (regWr && regAddr == CTRL_OFS) begin
			keepRunningInSleep_r <= regWrData[KEEP_RUN_BIT]; // see RULE19
		end else if (regWr && regAddr == MODE_OFS) begin
			splitMode_r <= regWrData[SPLIT_BIT];
		end
	end

	// Event control and interrupt enables
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			eventControl_r <= REG_RESET;
			irqEnable_r <= REG_RESET;
		end else if (regWr && regAddr == EVENT_CONTROL_REG_OFS) begin
			eventControl_r <= regWrData; // see RULE7
		end else if (regWr && regAddr == IRQEN_OFS) begin
			irqEnable_r <= regWrData & IRQ_MASK; // see RULE16
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		rdData_nxt = REG_RESET;
		case (regAddr)
			CTRL_OFS: rdData_nxt[KEEP_RUN_BIT] = keepRunningInSleep_r;
			MODE_OFS: rdData_nxt[SPLIT_BIT] = splitMode_r;
			EVENT_CONTROL_REG_OFS: rdData_nxt = eventControl_r;
			IRQEN_OFS: rdData_nxt = irqEnable_r;
			IRQFLAG_OFS: rdData_nxt = irqFlags;
			default: rdData_nxt = REG_RESET;
		endcase
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdData_r <= REG_RESET;
		end else if (regRd) begin
			rdData_r <= rdData_nxt;
		end else begin
			rdData_r <= REG_RESET;
		end
	end

	// Edge finders for both event inputs
	event_edge_detect edgeA (
		.clk(clk),
		.rst(rst),
		.level(eventInputA),
		.rise(aRise),
		.anyEdge(aAny)
	);

	event_edge_detect edgeB (
		.clk(clk),
		.rst(rst),
		.level(eventInputB),
		.rise(bRise),
		.anyEdge(bAny)
	);

	// Inputs act only when enabled, outside split mode and while running
	assign aActive = eventControl_r[A_EN_BIT] & ~splitMode_r & run; // see RULE7 see RULE9
	assign bActive = eventControl_r[B_EN_BIT] & ~splitMode_r & run; // see RULE7 see RULE9
	assign aAct = a_action_t'(eventControl_r[A_ACT_LSB +: 3]);
	assign bAct = b_action_t'(eventControl_r[B_ACT_LSB +: 3]);
	assign dirA = aActive & (aAct == A_DIRECTION);
	assign dirB = bActive & (bAct == B_DIRECTION);

	// Input A counting actions
	always_comb begin
		countGate_nxt = 1'b0;
		countPulse_nxt = 1'b0;
		if (aActive) begin
			case (aAct)
				A_COUNT_RISE: begin
					countGate_nxt = 1'b1;
					countPulse_nxt = aRise; // see RULE4
				end
				A_COUNT_ANY: begin
					countGate_nxt = 1'b1;
					countPulse_nxt = aAny; // see RULE4
				end
				A_COUNT_HIGH: begin
					countGate_nxt = 1'b1;
					countPulse_nxt = eventInputA; // see RULE4
				end
				default: begin
					countGate_nxt = 1'b0;
					countPulse_nxt = 1'b0;
				end
			endcase
		end
	end

	// Input B restart actions
	always_comb begin
		restart_nxt = 1'b0;
		if (bActive) begin
			case (bAct)
				B_RESTART_RISE: restart_nxt = bRise; // see RULE5
				B_RESTART_ANY: restart_nxt = bAny; // see RULE5
				B_RESTART_HIGH: restart_nxt = eventInputB; // see RULE5
				default: restart_nxt = 1'b0;
			endcase
		end
	end

	// Registered controls toward the counter core, one cycle after the input
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			countGate_r <= 1'b0;
			countPulse_r <= 1'b0;
			dirActive_r <= 1'b0;
			dirDown_r <= 1'b0;
			restart_r <= 1'b0;
		end else begin
			countGate_r <= countGate_nxt;
			countPulse_r <= countPulse_nxt;
			dirActive_r <= dirA | dirB;
			// Levels ORed: up only while every direction input is low
			dirDown_r <= (dirA & eventInputA) | (dirB & eventInputB); // see RULE6 see RULE8
			restart_r <= restart_nxt;
		end
	end

	// Interrupt conditions, only on a count step and only while running
	always_comb begin
		wrapCond = 1'b0;
		highCond = 1'b0;
		if (run && countStep) begin
			if (splitMode_r) begin
				wrapCond = cntValue[7:0] == BYTE_BOTTOM; // see RULE13
				highCond = cntValue[15:8] == BYTE_BOTTOM; // see RULE13
			end else begin
				wrapCond = countingDown ? (cntValue == CNT_BOTTOM) : (cntValue == perValue); // see RULE11
			end
		end
	end

	// Compare conditions share the mode-aware width choice
	assign cmpCond[0] = run & countStep & // see RULE12 see RULE14
		cmpHit(splitMode_r, cntValue, cmp0Value);
	assign cmpCond[1] = run & countStep & // see RULE12 see RULE14
		cmpHit(splitMode_r, cntValue, cmp1Value);
	assign cmpCond[2] = run & countStep & // see RULE12 see RULE14
		cmpHit(splitMode_r, cntValue, cmp2Value);

	// Flag bits set from the very same terms that raise the event pulses
	always_comb begin
		flagSet = REG_RESET;
		flagSet[WRAP_BIT] = wrapCond;
		flagSet[HIGH_BIT] = highCond;
		flagSet[CMP_LSB +: CMP_CH] = cmpCond; // see RULE3 see RULE15
	end

	// Write-one clear; zero bits leave their flags alone
	assign flagClr = (regWr && regAddr == IRQFLAG_OFS) ? // see RULE21
		(regWrData & IRQ_MASK) : REG_RESET;

	irq_flag_bank #(
		.WIDTH(DATA_W)
	) flagBank (
		.clk(clk),
		.rst(rst),
		.setVec(flagSet),
		.clrVec(flagClr),
		.enVec(irqEnable_r),
		.flags_r(irqFlags),
		.req(irqReq)
	);

	// Event pulses land on the same edge that sets the flags
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrapEvent_r <= 1'b0;
			highEvent_r <= 1'b0;
			cmpEvent_r <= '0;
		end else begin
			wrapEvent_r <= wrapCond; // see RULE1 see RULE3
			highEvent_r <= highCond; // see RULE1
			cmpEvent_r <= cmpCond; // see RULE2
		end
	end

	assign regRdData = rdData_r;
	assign timerRun = run;
	assign splitMode = splitMode_r;
	assign eventCountGate = countGate_r;
	assign eventCountPulse = countPulse_r;
	assign eventDirActive = dirActive_r;
	assign eventDirDown = dirDown_r;
	assign restartReq = restart_r;
	assign wrapOrLowUnderflowEvent = wrapEvent_r;
	assign highByteUnderflowEvent = highEvent_r;
	assign compareMatchEventCh = cmpEvent_r;

	// Event pulse comes with its flag set
	wrap_flag_link_a: assert property (wrapOrLowUnderflowEvent |-> irqFlags[WRAP_BIT]) // see RULE3
		else $error("wrap event without flag");

	// High-byte event exists only in split mode
	high_split_only_a: assert property (highByteUnderflowEvent |-> $past(splitMode_r)) // see RULE1
		else $error("high underflow event outside split mode");

	// Compare events only after a count step while running
	cmp_on_step_a: assert property ( // see RULE2
		|compareMatchEventCh |-> $past(countStep) && $past(run))
		else $error("compare event without count step");

	// Split mode blocks every event input action
	split_inputs_off_a: assert property (splitMode_r && !$past(regWr) |=> // see RULE9
		!eventCountGate && !eventDirActive && !restartReq)
		else $error("event input acted in split mode");

	// ORed direction when both inputs steer direction
	dir_or_a: assert property (dirA && dirB |=> // see RULE8
		eventDirDown == $past(eventInputA | eventInputB))
		else $error("direction not ORed");

	// Disabled input A never gates counting
	input_a_enable_a: assert property (!eventControl_r[A_EN_BIT] |=> !eventCountGate) // see RULE7
		else $error("input A acted while disabled");

	// Request holds until the flag is cleared by a one
	irq_hold_a: assert property (irqReq[WRAP_BIT] && !flagClr[WRAP_BIT] && // see RULE17
		irqEnable_r[WRAP_BIT] && !(regWr && regAddr == IRQEN_OFS) |=> irqReq[WRAP_BIT])
		else $error("request dropped while flagged");

	// Write-one clears a flag unless a set meets it
	flag_clear_a: assert property ( // see RULE21
		flagClr[CMP_LSB] && !flagSet[CMP_LSB] |=> !irqFlags[CMP_LSB])
		else $error("flag not cleared by write one");

	// Power-down silences wrap, high-byte and compare events
	powerdown_halt_a: assert property (sleepPowerDown |=> !wrapOrLowUnderflowEvent && // see RULE20
		!highByteUnderflowEvent && compareMatchEventCh == '0)
		else $error("event during power-down");

	// Plain standby halts unless kept running
	standby_halt_a: assert property ( // see RULE18
		sleepStandby && !keepRunningInSleep_r |-> !timerRun)
		else $error("timer running in standby");

endmodule // timer_event_irq_sleep_logic

// file: rtl/timer_event_pkg.sv
package timer_event_pkg;

	// Register port geometry
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;

	// Register offsets on the byte-wide register port
	localparam logic [ADDR_W-1:0] CTRL_OFS = 6'h00;
	localparam logic [ADDR_W-1:0] MODE_OFS = 6'h03;
	localparam logic [ADDR_W-1:0] EVENT_CONTROL_REG_OFS = 6'h09;
	localparam logic [ADDR_W-1:0] IRQEN_OFS = 6'h0A;
	localparam logic [ADDR_W-1:0] IRQFLAG_OFS = 6'h0B;

	// Field positions
	localparam int KEEP_RUN_BIT = 7;
	localparam int SPLIT_BIT = 0;
	localparam int A_EN_BIT = 0;
	localparam int A_ACT_LSB = 1;
	localparam int B_EN_BIT = 4;
	localparam int B_ACT_LSB = 5;
	localparam int WRAP_BIT = 0;
	localparam int HIGH_BIT = 1;
	localparam int CMP_LSB = 4;
	localparam int CMP_CH = 3;

	// Implemented bits of the enable and flag registers
	localparam logic [DATA_W-1:0] IRQ_MASK = 8'h73;

	// Value after reset, and the counter and byte BOTTOM values
	localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
	localparam logic [15:0] CNT_BOTTOM = 16'h0000;
	localparam logic [7:0] BYTE_BOTTOM = 8'h00;

	// Input A actions
	typedef enum logic [2:0] {
		A_COUNT_RISE = 3'b000,
		A_COUNT_ANY = 3'b001,
		A_COUNT_HIGH = 3'b010,
		A_DIRECTION = 3'b011
	} a_action_t;

	// Input B actions
	typedef enum logic [2:0] {
		B_DIRECTION = 3'b011,
		B_RESTART_RISE = 3'b100,
		B_RESTART_ANY = 3'b101,
		B_RESTART_HIGH = 3'b110
	} b_action_t;

endpackage
